// File: rtl/clk_rst_pkg.sv
// Constants shared by the clock and reset generator.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz master clock.
`default_nettype none
package clk_rst_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] ADDR_BUS_CTRL = 32'h0000_0020; // Expansion bus control
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0024; // Reset and clock status
  localparam logic [7:0] BUS_CTRL_RESET = 8'h00; // Divide-by-4 after reset
  localparam int DIV_SEL_LSB = 0; // Divisor field low bit
  localparam int DIV_SEL_W = 2; // Divisor field width
  // Status bit positions
  localparam int ST_CPU_BIT = 0;
  localparam int ST_NP_BIT = 1;
  localparam int ST_COLD_BIT = 2;
  localparam int ST_SEL_LSB = 4;
  // ----------------------------------------
  // Bus protocol and ports
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [15:0] NP_RESET_PORT = 16'h00F1; // Coprocessor reset port
  // ----------------------------------------
  // Timing counts in master clock cycles, except OSC_HALF in oscillator rises
  // ----------------------------------------
  localparam logic [5:0] NP_HOLD_CYCLES = 6'h28; // 40 cycles least
  localparam logic [5:0] CPU_PULSE_CYCLES = 6'h28; // Soft reset pulse length
  localparam logic [2:0] OSC_HALF = 3'h6; // Half of the divide-by-12
  // Half periods of the bus clock for divide by 4, 6, 8, 10
  localparam logic [2:0] HALF_DIV4 = 3'h2;
  localparam logic [2:0] HALF_DIV6 = 3'h3;
  localparam logic [2:0] HALF_DIV8 = 3'h4;
  localparam logic [2:0] HALF_DIV10 = 3'h5;
  // ----------------------------------------
  // Reset sequencer states; COLD is one bit from RUN and from PULSE, but RUN to PULSE and back flips both bits
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_COLD = 2'b01,
    ST_PULSE = 2'b11
  } rst_state_e;
endpackage
`default_nettype wire

// File: rtl/system_clock_reset_gen.sv
// Clock and reset generator of the system controller.
// Assumes pin inputs are asynchronous and soft reset requests
// come from logic on the master clock.
//
// Operation
// - Processor reset on cold, fast, shutdown events
// - Coprocessor reset whenever processor reset is on
// - I/O write to F1h resets coprocessor
// - Coprocessor reset synced, held forty cycles least
// - System reset low follows cold reset input
// - All state runs on the master clock
// - Processor and coprocessor resets launch on early clock phase
// - Bus clock divides master by 4,6,8,10
// - Timebase oscillator divided by twelve
`default_nettype none
module system_clock_reset_gen (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cold_reset_in_n,
  input wire logic early_master_clock,
  input wire logic timebase_oscillator_in,
  input wire logic kbd_fast_reset,
  input wire logic shutdown_cycle,
  input wire logic io_write_strobe,
  input wire logic [15:0] io_write_addr,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic processor_reset_out,
  output logic coprocessor_reset_out,
  output logic system_reset_out_n,
  output logic expansion_bus_clock,
  output logic timebase_div_twelve_out
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sync_a; // First stages
  logic [2:0] sync_b; // Second stages
  logic [2:0] pin_in; // Raw pins
  logic cold_s; // Cold reset, high means run
  logic early_s; // Early clock phase, launch enable
  logic osc_s; // Oscillator level
  logic osc_d; // Oscillator delayed for edge detect
  logic osc_rise; // Oscillator rising edge

  assign pin_in = {timebase_oscillator_in, early_master_clock, cold_reset_in_n};

  // Two flops per pin; first flop feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign cold_s = sync_b[0];
  assign early_s = sync_b[1];
  assign osc_s = sync_b[2];
  assign osc_rise = osc_s & ~osc_d;

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  logic [7:0] bus_ctrl, next_bus_ctrl; // Divisor select lives here
  logic wr_pend, next_wr_pend; // Write data phase pending
  logic [31:0] wr_addr, next_wr_addr; // Address of pending write
  logic [31:0] next_hrdata;
  logic [31:0] status_word; // Live status view
  logic [7:0] ctrl_view; // Control value with write forwarding
  logic take; // Address phase accepted
  logic [1:0] active_sel; // Divisor in use by the bus clock

  // NONSEQ and SEQ both have the upper bit set; IDLE and BUSY are not taken
  assign take = hsel & hready & htrans[1];

  // Compute register file next values
  always_comb begin
    next_bus_ctrl = bus_ctrl;
    next_wr_pend = take & hwrite;
    next_wr_addr = take ? haddr : wr_addr;
    ctrl_view = bus_ctrl;
    // Data phase of a write updates the control register
    if (wr_pend && wr_addr == clk_rst_pkg::ADDR_BUS_CTRL) begin
      next_bus_ctrl = hwdata[7:0];
      ctrl_view = hwdata[7:0];
    end
    status_word = 32'h0000_0000;
    status_word[clk_rst_pkg::ST_CPU_BIT] = processor_reset_out;
    status_word[clk_rst_pkg::ST_NP_BIT] = coprocessor_reset_out;
    status_word[clk_rst_pkg::ST_COLD_BIT] = ~cold_s;
    status_word[clk_rst_pkg::ST_SEL_LSB +: clk_rst_pkg::DIV_SEL_W] = active_sel;
    next_hrdata = 32'h0000_0000;
    // Read data prepared for the next data phase; unmapped reads zero
    if (take && !hwrite) begin
      if (haddr == clk_rst_pkg::ADDR_BUS_CTRL) begin
        next_hrdata = {24'h00_0000, ctrl_view};
      end else if (haddr == clk_rst_pkg::ADDR_STATUS) begin
        next_hrdata = status_word;
      end
    end
  end

  // Register bus state; slave never waits and always answers OKAY
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_ctrl <= clk_rst_pkg::BUS_CTRL_RESET;
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      bus_ctrl <= next_bus_ctrl;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  clk_rst_pkg::rst_state_e state, next_state;
  logic [5:0] pulse_cnt, next_pulse_cnt; // Soft reset pulse timer
  logic [5:0] np_cnt, next_np_cnt; // Coprocessor hold timer
  logic cpu_req; // Processor reset wanted
  logic np_write; // Write to coprocessor reset port
  logic next_cpu_out, next_np_out, next_sys_n;

  assign cpu_req = (state != clk_rst_pkg::ST_RUN);
  assign np_write = io_write_strobe & (io_write_addr == clk_rst_pkg::NP_RESET_PORT);

  // Next state of resets
  always_comb begin
    next_state = state;
    next_pulse_cnt = pulse_cnt;
    next_np_cnt = np_cnt;
    case (state)
      clk_rst_pkg::ST_RUN: begin
        if (!cold_s) begin
          next_state = clk_rst_pkg::ST_COLD;
        end else if (kbd_fast_reset || shutdown_cycle) begin
          next_state = clk_rst_pkg::ST_PULSE;
          next_pulse_cnt = clk_rst_pkg::CPU_PULSE_CYCLES;
        end
      end
      clk_rst_pkg::ST_COLD: begin
        // Held while the board keeps cold reset low
        if (cold_s) begin
          next_state = clk_rst_pkg::ST_RUN;
        end
      end
      clk_rst_pkg::ST_PULSE: begin
        if (!cold_s) begin
          next_state = clk_rst_pkg::ST_COLD;
        end else if (pulse_cnt <= 6'h01) begin
          next_state = clk_rst_pkg::ST_RUN;
          next_pulse_cnt = 6'h00;
        end else begin
          next_pulse_cnt = pulse_cnt - 6'h01;
        end
      end
      default: begin
        next_state = clk_rst_pkg::ST_COLD;
      end
    endcase
    // Timer reloads on any trigger, counts only while output is high
    if (cpu_req || np_write) begin
      next_np_cnt = clk_rst_pkg::NP_HOLD_CYCLES;
    end else if (coprocessor_reset_out && np_cnt != 6'h00) begin
      next_np_cnt = np_cnt - 6'h01;
    end
    next_cpu_out = processor_reset_out;
    next_np_out = coprocessor_reset_out;
    // Processor and coprocessor outputs move only on the early clock phase
    if (early_s) begin
      next_cpu_out = cpu_req;
      next_np_out = cpu_req | (np_cnt != 6'h00);
    end
    next_sys_n = cold_s;
  end

  // Reset state registers, all on the master clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= clk_rst_pkg::ST_COLD;
      pulse_cnt <= 6'h00;
      np_cnt <= clk_rst_pkg::NP_HOLD_CYCLES;
      processor_reset_out <= 1'b1;
      coprocessor_reset_out <= 1'b1;
      system_reset_out_n <= 1'b0;
    end else begin
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      np_cnt <= next_np_cnt;
      processor_reset_out <= next_cpu_out;
      coprocessor_reset_out <= next_np_out;
      system_reset_out_n <= next_sys_n;
    end
  end

  // ----------------------------------------
  // Clock dividers
  // ----------------------------------------
  logic [2:0] bc_cnt, next_bc_cnt; // Bus clock half period counter
  logic [1:0] next_active_sel;
  logic next_bus_clk;
  logic [2:0] osc_cnt, next_osc_cnt; // Oscillator edge counter
  logic next_osc_out;

  // Half period for each field code
  function automatic logic [2:0] div_half(input logic [1:0] sel);
    case (sel)
      2'h0: div_half = clk_rst_pkg::HALF_DIV4;
      2'h1: div_half = clk_rst_pkg::HALF_DIV6;
      2'h2: div_half = clk_rst_pkg::HALF_DIV8;
      default: div_half = clk_rst_pkg::HALF_DIV10;
    endcase
  endfunction

  // Next values of both dividers
  always_comb begin
    next_bc_cnt = bc_cnt + 3'h1;
    next_bus_clk = expansion_bus_clock;
    next_active_sel = active_sel;
    if (bc_cnt == div_half(active_sel) - 3'h1) begin
      next_bc_cnt = 3'h0;
      next_bus_clk = ~expansion_bus_clock;
      // New divisor taken only where a period starts
      if (!expansion_bus_clock) begin
        next_active_sel = bus_ctrl[clk_rst_pkg::DIV_SEL_LSB +: clk_rst_pkg::DIV_SEL_W];
      end
    end
    next_osc_cnt = osc_cnt;
    next_osc_out = timebase_div_twelve_out;
    if (osc_rise) begin
      if (osc_cnt == clk_rst_pkg::OSC_HALF - 3'h1) begin
        next_osc_cnt = 3'h0;
        next_osc_out = ~timebase_div_twelve_out;
      end else begin
        next_osc_cnt = osc_cnt + 3'h1;
      end
    end
  end

  // Divider registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bc_cnt <= 3'h0;
      active_sel <= 2'h0;
      expansion_bus_clock <= 1'b0;
      osc_cnt <= 3'h0;
      osc_d <= 1'b0;
      timebase_div_twelve_out <= 1'b0;
    end else begin
      bc_cnt <= next_bc_cnt;
      active_sel <= next_active_sel;
      expansion_bus_clock <= next_bus_clk;
      osc_cnt <= next_osc_cnt;
      osc_d <= osc_s;
      timebase_div_twelve_out <= next_osc_out;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_cold_cpu: assert property (
    state == clk_rst_pkg::ST_COLD && early_s |=> processor_reset_out)
    else $error("Processor reset missed cold reset");
  chk_soft_pulse: assert property (
    state == clk_rst_pkg::ST_RUN && cold_s && shutdown_cycle
    |=> state == clk_rst_pkg::ST_PULSE)
    else $error("Shutdown did not start reset pulse");
  chk_np_follows: assert property (
    processor_reset_out |-> coprocessor_reset_out)
    else $error("Coprocessor reset not with processor reset");
  chk_np_port: assert property (
    np_write |=> np_cnt == clk_rst_pkg::NP_HOLD_CYCLES)
    else $error("Port write did not load coprocessor timer");
  chk_np_rise: assert property (
    $rose(coprocessor_reset_out) |-> np_cnt == clk_rst_pkg::NP_HOLD_CYCLES)
    else $error("Coprocessor reset rose without full count");
  chk_np_fall: assert property (
    $fell(coprocessor_reset_out) |-> $past(np_cnt) == 6'h00 && !$past(cpu_req))
    else $error("Coprocessor reset ended early");
  chk_sys_reset: assert property (
    !cold_s |=> !system_reset_out_n)
    else $error("System reset not driven by cold reset");
  chk_launch_phase: assert property (
    $changed(processor_reset_out) |-> $past(early_s))
    else $error("Processor reset moved off early phase");
  chk_bus_half: assert property (
    $changed(expansion_bus_clock) |-> $past(bc_cnt) == div_half($past(active_sel)) - 3'h1)
    else $error("Bus clock half period wrong");
  chk_sel_boundary: assert property (
    $changed(active_sel) |-> $rose(expansion_bus_clock))
    else $error("Divisor changed inside a period");
  chk_osc_twelve: assert property (
    $changed(timebase_div_twelve_out)
    |-> $past(osc_rise) && $past(osc_cnt) == clk_rst_pkg::OSC_HALF - 3'h1)
    else $error("Timebase divide by twelve wrong");
endmodule
`default_nettype wire

// File: dv/far_side_model.sv
// Far-side model: board reset wiring, timebase oscillator and pin monitors.
// Assumes the master clock and the generator's outputs are wired to it.
`default_nettype none
module far_side_model (
  input wire logic clock,
  input wire logic switch_n,
  input wire logic power_good,
  input wire logic processor_reset_out,
  input wire logic coprocessor_reset_out,
  input wire logic expansion_bus_clock,
  input wire logic timebase_div_twelve_out,
  output logic cold_reset_in_n,
  output logic timebase_oscillator_in,
  output logic [7:0] cpu_len,
  output logic [7:0] np_len,
  output logic [7:0] bus_half,
  output logic [7:0] osc_per_half
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cpu_cnt = 8'h00; // Processor reset high run
  logic [7:0] np_cnt = 8'h00; // Coprocessor reset high run
  logic [7:0] hi_cnt = 8'h00; // Bus clock high run
  logic [7:0] osc_cnt = 8'h00; // Oscillator rises since last output change
  logic osc_q = 1'b0; // Previous oscillator sample
  logic tb_q = 1'b0; // Previous timebase output sample
  logic osc_rise; // Oscillator rise seen this cycle
  // --------------------------------------------
  // Board wiring
  // --------------------------------------------
  // Either source low calls for a cold reset
  assign cold_reset_in_n = switch_n & power_good;
  // Free-running oscillator near 14.2 MHz; its edges never meet a rising master clock edge
  initial begin
    timebase_oscillator_in = 1'b0;
    forever #35.2 timebase_oscillator_in = ~timebase_oscillator_in;
  end
  // --------------------------------------------
  // Monitors
  // --------------------------------------------
  assign osc_rise = timebase_oscillator_in & ~osc_q;
  // High-phase lengths in master cycles, stored when each phase ends
  always @(posedge clock) begin
    cpu_cnt <= processor_reset_out ? cpu_cnt + 8'h01 : 8'h00;
    np_cnt <= coprocessor_reset_out ? np_cnt + 8'h01 : 8'h00;
    hi_cnt <= expansion_bus_clock ? hi_cnt + 8'h01 : 8'h00;
    if (!processor_reset_out && cpu_cnt != 8'h00) begin
      cpu_len <= cpu_cnt;
    end
    if (!coprocessor_reset_out && np_cnt != 8'h00) begin
      np_len <= np_cnt;
    end
    if (!expansion_bus_clock && hi_cnt != 8'h00) begin
      bus_half <= hi_cnt;
    end
    osc_q <= timebase_oscillator_in;
    tb_q <= timebase_div_twelve_out;
    // Oscillator rises between two changes of the divided output
    if (timebase_div_twelve_out != tb_q) begin
      osc_per_half <= osc_cnt;
      osc_cnt <= {7'h00, osc_rise};
    end else begin
      osc_cnt <= osc_cnt + {7'h00, osc_rise};
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_system_clock_reset_gen.sv
// Self-checking bench for the clock and reset generator.
// Assumes a single AHB-Lite slave and the far-side model beside it.
`default_nettype none
module tb_system_clock_reset_gen;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, early_master_clock, kbd_fast_reset, shutdown_cycle;
  logic io_write_strobe, hsel, hwrite, switch_n, power_good;
  logic [15:0] io_write_addr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready; // Single slave: its ready is the bus ready
  logic hreadyout, hresp, processor_reset_out, coprocessor_reset_out;
  logic system_reset_out_n, expansion_bus_clock, timebase_div_twelve_out;
  logic cold_reset_in_n, timebase_oscillator_in;
  logic [7:0] cpu_len, np_len, bus_half, osc_per_half;
  int n_fail = 0; // Mismatches
  int n_checks = 0; // Comparisons made
  assign hready = hreadyout;
  // --------------------------------------------
  // Instances
  // --------------------------------------------
  system_clock_reset_gen u_system_clock_reset_gen (.clock(clock), .rst_n(rst_n),
    .cold_reset_in_n(cold_reset_in_n), .early_master_clock(early_master_clock),
    .timebase_oscillator_in(timebase_oscillator_in), .kbd_fast_reset(kbd_fast_reset),
    .shutdown_cycle(shutdown_cycle), .io_write_strobe(io_write_strobe),
    .io_write_addr(io_write_addr), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .processor_reset_out(processor_reset_out),
    .coprocessor_reset_out(coprocessor_reset_out), .system_reset_out_n(system_reset_out_n),
    .expansion_bus_clock(expansion_bus_clock),
    .timebase_div_twelve_out(timebase_div_twelve_out));
  far_side_model u_far_side_model (.clock(clock), .switch_n(switch_n),
    .power_good(power_good), .processor_reset_out(processor_reset_out),
    .coprocessor_reset_out(coprocessor_reset_out), .expansion_bus_clock(expansion_bus_clock),
    .timebase_div_twelve_out(timebase_div_twelve_out), .cold_reset_in_n(cold_reset_in_n),
    .timebase_oscillator_in(timebase_oscillator_in), .cpu_len(cpu_len), .np_len(np_len),
    .bus_half(bus_half), .osc_per_half(osc_per_half));
  // --------------------------------------------
  // Tasks
  // --------------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-bit compare
  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask
  // Single write: address phase, then data phase
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= clk_rst_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b1; hsize <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
  endtask
  // Single read: data taken at the edge that ends the data phase
  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= clk_rst_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b0; hsize <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0;
    do @(posedge clock); while (hready !== 1'b1);
    d = hrdata;
    chk1(hresp, 1'b0);
  endtask
  // One-cycle request: 0 fast reset, 1 shutdown, 2 I/O write
  task automatic pulse(input int k, input logic [15:0] a);
    io_write_addr <= a;
    kbd_fast_reset <= (k == 0); shutdown_cycle <= (k == 1); io_write_strobe <= (k == 2);
    @(posedge clock);
    kbd_fast_reset <= 1'b0; shutdown_cycle <= 1'b0; io_write_strobe <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // --------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Run needs about 700 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude();
  end
  initial begin
    rst_n = 1'b0; early_master_clock = 1'b1; kbd_fast_reset = 1'b0; shutdown_cycle = 1'b0;
    io_write_strobe = 1'b0; io_write_addr = 16'h0000; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    switch_n = 1'b1; power_good = 1'b1;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    bus_read(clk_rst_pkg::ADDR_BUS_CTRL, rd);
    check(rd, {24'h0, clk_rst_pkg::BUS_CTRL_RESET});
    bus_read(32'h0000_0100, rd);
    check(rd, 32'h0);
    // Every divisor code, with upper control bits set; bits above 7 read back as zero
    for (int s = 0; s < 4; s++) begin
      bus_write(clk_rst_pkg::ADDR_BUS_CTRL, 32'hFFFF_FFFC | 32'(s));
      repeat (40) @(posedge clock);
      check({24'h0, bus_half}, 32'(s + 2));
      bus_read(clk_rst_pkg::ADDR_BUS_CTRL, rd);
      check(rd, 32'h0000_00FC | 32'(s));
      bus_read(clk_rst_pkg::ADDR_STATUS, rd);
      check(rd & 32'h30, 32'(s) << 4);
    end
    check({24'h0, osc_per_half}, 32'h6);
    // Cold reset from each board source
    for (int i = 0; i < 2; i++) begin
      if (i == 0) switch_n <= 1'b0; else power_good <= 1'b0;
      repeat (10) @(posedge clock);
      chk1(processor_reset_out, 1'b1);
      chk1(coprocessor_reset_out, 1'b1);
      chk1(system_reset_out_n, 1'b0);
      switch_n <= 1'b1; power_good <= 1'b1;
      repeat (10) @(posedge clock);
      chk1(processor_reset_out, 1'b0);
      chk1(system_reset_out_n, 1'b1);
      chk1(coprocessor_reset_out, 1'b1);
      repeat (60) @(posedge clock);
      chk1(np_len >= 8'd40, 1'b1);
    end
    // Fast reset and shutdown
    for (int k = 0; k < 2; k++) begin
      pulse(k, 16'h0000);
      repeat (5) @(posedge clock);
      chk1(processor_reset_out, 1'b1);
      chk1(coprocessor_reset_out, 1'b1);
      chk1(system_reset_out_n, 1'b1);
      repeat (100) @(posedge clock);
      check({24'h0, cpu_len}, 32'd40);
      chk1(np_len >= 8'd40, 1'b1);
    end
    // Port write held back while the early phase is low; low level crosses the syncs first
    early_master_clock <= 1'b0;
    repeat (3) @(posedge clock);
    pulse(2, clk_rst_pkg::NP_RESET_PORT);
    repeat (10) @(posedge clock);
    chk1(coprocessor_reset_out, 1'b0);
    early_master_clock <= 1'b1;
    repeat (6) @(posedge clock);
    chk1(coprocessor_reset_out, 1'b1);
    chk1(processor_reset_out, 1'b0);
    repeat (80) @(posedge clock);
    chk1(np_len >= 8'd40, 1'b1);
    // Neighbouring port leaves the coprocessor alone
    pulse(2, 16'h00F0);
    repeat (10) @(posedge clock);
    chk1(coprocessor_reset_out, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
